// *** src/dgoc_pkg.sv ***
// Constants and state type for the global operation control of a six-channel DMA.
// Assumes a single 20 MHz clock and a plain register port with word addresses.
// Function
// [RULE_01] The global operation register is sixteen bits, read and write by software.
// [RULE_02] Reset clears it to zero; it holds its value through standby.
// [RULE_03] Bits 15 to 10 and 7 to 3 read zero; software writes zero.
// [RULE_04] Priority 00 serves channels in order 0,1,2,3,4,5.
// [RULE_05] Priority 01 serves channels in order 0,2,3,1,4,5.
// [RULE_06] Priority 11 arbitrates all channels round-robin.
// [RULE_07] Software never writes priority value 10; it is reserved.
// [RULE_08] An address error sets bit 2 and blocks all transfers.
// [RULE_09] Flags clear only by writing 0 after reading 1; writing 1 does nothing.
// [RULE_10] A non-maskable interrupt sets bit 1 and blocks all transfers.
// [RULE_11] The NMI flag sets even when the controller is idle.
// [RULE_12] An NMI during a transfer lets the current unit finish, then stops.
// [RULE_13] Master enable bit 0 gates transfers on every channel.
// [RULE_14] A channel runs only with both enables set and all three flags clear.
// [RULE_15] Clearing master enable terminates transfers on all channels.
// [RULE_16] Transfer-end sets only when the count reaches zero, not on early stop.
// [RULE_17] Clearing a channel enable stops it; setting both enables starts auto-request.
// [RULE_18] In round-robin the channel just served drops to lowest priority.
package dgoc_pkg;

  localparam int          NUM_CHAN      = 6;
  localparam logic [1:0]  ADDR_GLOBAL   = 2'h0;
  localparam logic [1:0]  ADDR_IRQ_STAT = 2'h1;
  localparam logic [1:0]  ADDR_IRQ_MASK = 2'h2;
  localparam int          BIT_MASTER_EN = 0;
  localparam int          BIT_NMI_FLAG  = 1;
  localparam int          BIT_ADDR_ERR  = 2;
  localparam int          BIT_PRIO_LO   = 8;
  localparam logic [15:0] GLOBAL_RESET  = 16'h0000;
  localparam logic [1:0]  PRIO_FIXED1   = 2'h0;
  localparam logic [1:0]  PRIO_FIXED2   = 2'h1;
  localparam logic [1:0]  PRIO_ROUND    = 2'h3;
  localparam int          IRQ_ADDR_ERR  = 0;
  localparam int          IRQ_NMI       = 1;
  localparam int          IRQ_END       = 2;
  localparam logic [2:0]  IRQ_RESET     = 3'h0;
  localparam logic [2:0]  RR_RESET      = 3'h5;
  // Service order of the second fixed mode, lowest first as written; the low three bits hold the highest.
  localparam logic [17:0] ORDER_FIXED2  = {3'h5, 3'h4, 3'h1, 3'h3, 3'h2, 3'h0};

  typedef struct packed {
    logic [1:0]  prio;
    logic        addrErr;
    logic        nmiFlag;
    logic        masterEn;
    logic        addrSeen;
    logic        nmiSeen;
    logic        nmiS1;
    logic        nmiS2;
    logic        nmiPrev;
    logic        busy;
    logic [2:0]  chan;
    logic [2:0]  rrLast;
    logic [2:0]  irqStat;
    logic [2:0]  irqMask;
    logic [15:0] rdData;
    logic [5:0]  endPulse;
  } dgoc_state_t;

endpackage

// *** src/dgoc_top.sv ***
// Global operation control: priority selection, master enable, error flags, arbiter.
// Assumes channel inputs come from logic on clk_sys and the NMI line from a pin.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module dgoc_top
  import dgoc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [1:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  input  wire logic [5:0]  chanEnable,
  input  wire logic [5:0]  chanTransferEnd,
  input  wire logic [5:0]  chanRequest,
  input  wire logic        unitDone,
  input  wire logic        unitLast,
  input  wire logic        addrErrorEvent,
  input  wire logic        nmiPin,
  output logic      [5:0]  chanPermit,
  output logic             grantValid,
  output logic      [2:0]  grantChannel,
  output logic      [5:0]  transferEndSet,
  output logic             irq
);

  dgoc_state_t st_r;
  dgoc_state_t st_nxt;
  logic [5:0]  eligible;
  logic [3:0]  pick;
  logic        abortNow;
  logic        nmiEdge;
  logic [15:0] globalView;

  // Picks the next channel; bit 3 says whether any channel was found.
  function automatic logic [3:0] pickChannel(input logic [5:0] req, input logic [1:0] mode,
                                             input logic [2:0] last);
    logic [3:0] res;
    logic [2:0] idx;
    res = 4'h0;
    for (int i = NUM_CHAN; i >= 1; i--) begin
      if (mode == PRIO_ROUND) begin
        idx = 3'((int'(last) + i) % NUM_CHAN); // [RULE_06] [RULE_18]
      end else if (mode == PRIO_FIXED2) begin
        idx = ORDER_FIXED2[3*(i-1) +: 3]; // [RULE_05]
      end else begin
        idx = 3'(i - 1); // [RULE_04]
      end
      if (req[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  // Register image; reserved positions are constant zero.
  assign globalView = {6'h00, st_r.prio, 5'h00, st_r.addrErr, st_r.nmiFlag,
                       st_r.masterEn}; // [RULE_01] [RULE_03]

  // Permission per channel from both enables and all three blocking flags.
  assign chanPermit = chanEnable & ~chanTransferEnd &
                      {NUM_CHAN{st_r.masterEn & ~st_r.addrErr & ~st_r.nmiFlag}}; // [RULE_14]
  assign eligible   = chanPermit & chanRequest;
  assign pick       = pickChannel(eligible, st_r.prio, st_r.rrLast);
  // An NMI does not abort; the running unit completes and no new grant follows.
  assign abortNow   = ~st_r.masterEn | st_r.addrErr | ~chanEnable[st_r.chan]; // [RULE_15]
  assign nmiEdge    = st_r.nmiS2 & ~st_r.nmiPrev;

  assign regRdData      = st_r.rdData;
  assign grantValid     = st_r.busy;
  assign grantChannel   = st_r.chan;
  assign transferEndSet = st_r.endPulse;
  assign irq            = |(st_r.irqStat & st_r.irqMask);

  // Next-state logic for the whole block.
  always_comb begin
    st_nxt          = st_r;
    st_nxt.nmiS1    = nmiPin;
    st_nxt.nmiS2    = st_r.nmiS1;
    st_nxt.nmiPrev  = st_r.nmiS2;
    st_nxt.rdData   = 16'h0000;
    st_nxt.endPulse = 6'h00;
    // Reads return data in the following cycle; a read of a set flag arms its clear.
    if (regRd) begin
      case (regAddr)
        ADDR_GLOBAL: begin
          st_nxt.rdData = globalView;
          if (st_r.addrErr) st_nxt.addrSeen = 1'b1; // [RULE_09]
          if (st_r.nmiFlag) st_nxt.nmiSeen = 1'b1; // [RULE_09]
        end
        ADDR_IRQ_STAT: st_nxt.rdData = {13'h0000, st_r.irqStat};
        ADDR_IRQ_MASK: st_nxt.rdData = {13'h0000, st_r.irqMask};
        default:       st_nxt.rdData = 16'h0000;
      endcase
    end
    // Writes; a one to either flag is ignored, a zero clears only once armed.
    if (regWr) begin
      case (regAddr)
        ADDR_GLOBAL: begin
          st_nxt.prio     = regWrData[BIT_PRIO_LO +: 2];
          st_nxt.masterEn = regWrData[BIT_MASTER_EN]; // [RULE_13]
          if (!regWrData[BIT_ADDR_ERR] && st_r.addrSeen) begin
            st_nxt.addrErr  = 1'b0; // [RULE_09]
            st_nxt.addrSeen = 1'b0;
          end
          if (!regWrData[BIT_NMI_FLAG] && st_r.nmiSeen) begin
            st_nxt.nmiFlag = 1'b0; // [RULE_09]
            st_nxt.nmiSeen = 1'b0;
          end
        end
        ADDR_IRQ_STAT: st_nxt.irqStat = st_r.irqStat & ~regWrData[2:0];
        ADDR_IRQ_MASK: st_nxt.irqMask = regWrData[2:0];
        default: ;
      endcase
    end
    // Hardware events set the flags after any clear, so a set is never lost.
    if (addrErrorEvent) begin
      st_nxt.addrErr               = 1'b1; // [RULE_08]
      st_nxt.irqStat[IRQ_ADDR_ERR] = 1'b1;
    end
    if (nmiEdge) begin
      st_nxt.nmiFlag          = 1'b1; // [RULE_10] [RULE_11]
      st_nxt.irqStat[IRQ_NMI] = 1'b1;
    end
    // Arbiter: one unit at a time, granted only to a permitted requester.
    if (st_r.busy) begin
      if (abortNow) begin
        st_nxt.busy = 1'b0; // [RULE_15] [RULE_17]
      end else if (unitDone) begin
        st_nxt.busy   = 1'b0; // [RULE_12]
        st_nxt.rrLast = st_r.chan; // [RULE_18]
        if (unitLast) begin
          st_nxt.endPulse[st_r.chan] = 1'b1; // [RULE_16]
          st_nxt.irqStat[IRQ_END]    = 1'b1;
        end
      end
    end else if (pick[3]) begin
      st_nxt.busy = 1'b1; // [RULE_14] [RULE_17]
      st_nxt.chan = pick[2:0];
    end
  end

  // All state in one register; nothing else is clocked, so standby keeps the value.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r          <= '0; // [RULE_02]
      st_r.prio     <= GLOBAL_RESET[BIT_PRIO_LO +: 2];
      st_r.masterEn <= GLOBAL_RESET[BIT_MASTER_EN];
      st_r.rrLast   <= RR_RESET;
      st_r.irqMask  <= IRQ_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Helper: the channel that the first fixed mode must pick from the current eligible set.
  logic [2:0] expFixed;
  always_comb begin
    expFixed = 3'h0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (eligible[i]) expFixed = 3'(i);
    end
  end

  sequence s_grantIdle;
    !st_r.busy && (eligible != 6'h00);
  endsequence

  property p_fixedOrder1;
    s_grantIdle and (st_r.prio == PRIO_FIXED1) |=> grantValid && grantChannel == $past(expFixed);
  endproperty
  a_fixedOrder1: assert property (p_fixedOrder1) else $error("Fixed order 1 violated"); // [RULE_04]

  property p_fixedOrder2;
    s_grantIdle and (st_r.prio == PRIO_FIXED2) and (eligible[3:0] == 4'b0110) |=>
      grantChannel == 3'h2;
  endproperty
  a_fixedOrder2: assert property (p_fixedOrder2) else $error("Fixed order 2 violated"); // [RULE_05]

  property p_roundRobin;
    s_grantIdle and (st_r.prio == PRIO_ROUND) and (eligible == 6'h3F) |=>
      grantChannel == 3'(($past(st_r.rrLast) + 3'h1) % 3'h6);
  endproperty
  a_roundRobin: assert property (p_roundRobin) else $error("Round-robin order violated"); // [RULE_06]

  property p_readZeros;
    regRd |=> (regRdData[15:10] == 6'h00) && (regRdData[7:3] == 5'h00);
  endproperty
  a_readZeros: assert property (p_readZeros) else $error("Reserved bits read nonzero"); // [RULE_03]

  property p_addrErrSet;
    addrErrorEvent |=> st_r.addrErr ##1 (chanPermit == 6'h00);
  endproperty
  a_addrErrSet: assert property (p_addrErrSet) else $error("Address error not blocking"); // [RULE_08]

  property p_noClearUnread;
    st_r.nmiFlag && !st_r.nmiSeen && !regRd |=> st_r.nmiFlag;
  endproperty
  a_noClearUnread: assert property (p_noClearUnread) else $error("NMI flag cleared unread"); // [RULE_09]

  property p_nmiSet;
    $rose(st_r.nmiS2) |=> st_r.nmiFlag ##1 (chanPermit == 6'h00);
  endproperty
  a_nmiSet: assert property (p_nmiSet) else $error("NMI flag not set or not blocking"); // [RULE_10]

  property p_nmiFinishUnit;
    st_r.busy && st_r.nmiFlag && !abortNow && !unitDone |=> st_r.busy;
  endproperty
  a_nmiFinishUnit: assert property (p_nmiFinishUnit) else $error("NMI cut a unit short"); // [RULE_12]

  property p_masterOff;
    st_r.busy && !st_r.masterEn |=> !grantValid;
  endproperty
  a_masterOff: assert property (p_masterOff) else $error("Transfer kept without master enable"); // [RULE_15]

  property p_endOnlyNormal;
    transferEndSet != 6'h00 |-> $past(unitDone && unitLast && !abortNow && st_r.busy);
  endproperty
  a_endOnlyNormal: assert property (p_endOnlyNormal) else $error("Transfer end set on early stop"); // [RULE_16]

  // A unit that ends normally, neither aborted nor refused.
  sequence s_unitEnds;
    st_r.busy && !abortNow && unitDone;
  endsequence

  // A unit that keeps running through this cycle.
  sequence s_unitHolds;
    st_r.busy && !abortNow && !unitDone;
  endsequence

  // A read of the global index returns the image seen at the strobe.
  property p_readGlobal;
    regRd && (regAddr == ADDR_GLOBAL) |=> regRdData == $past(globalView);
  endproperty
  a_readGlobal: assert property (p_readGlobal) else $error("Global read image wrong"); // [RULE_01]

  // Read data stand one cycle only, so idle cycles return zero.
  property p_rdIdleZero;
    !regRd |=> regRdData == 16'h0000;
  endproperty
  a_rdIdleZero: assert property (p_rdIdleZero) else $error("Read data not zero when idle"); // [RULE_01]

  // A write to the global index lands in priority and master enable.
  property p_writeImage;
    regWr && (regAddr == ADDR_GLOBAL) |=>
      (st_r.prio == $past(regWrData[9:8])) && (st_r.masterEn == $past(regWrData[0]));
  endproperty
  a_writeImage: assert property (p_writeImage) else $error("Global write not taken"); // [RULE_13]

  // Reserved positions stay zero whatever software writes.
  property p_reservedWrite;
    regWr && (regAddr == ADDR_GLOBAL) |=> (globalView[15:10] == 6'h00) &&
      (globalView[7:3] == 5'h00);
  endproperty
  a_reservedWrite: assert property (p_reservedWrite) else $error("Reserved bits took a write"); // [RULE_03]

  // Without a write priority and master enable keep their value; standby is just no write.
  property p_holdUnwritten;
    !regWr |=> $stable(st_r.prio) && $stable(st_r.masterEn);
  endproperty
  a_holdUnwritten: assert property (p_holdUnwritten) else $error("Register changed unwritten"); // [RULE_02]

  // Writing a one to the address-error flag never clears it.
  property p_addrWriteOne;
    st_r.addrErr && regWr && (regAddr == ADDR_GLOBAL) && regWrData[BIT_ADDR_ERR] |=>
      st_r.addrErr;
  endproperty
  a_addrWriteOne: assert property (p_addrWriteOne) else $error("Address error cleared by one"); // [RULE_09]

  // Writing a one to the NMI flag never clears it.
  property p_nmiWriteOne;
    st_r.nmiFlag && regWr && (regAddr == ADDR_GLOBAL) && regWrData[BIT_NMI_FLAG] |=>
      st_r.nmiFlag;
  endproperty
  a_nmiWriteOne: assert property (p_nmiWriteOne) else $error("NMI flag cleared by one"); // [RULE_09]

  // An address-error flag that was never read as one cannot be cleared.
  property p_addrNoClearUnread;
    st_r.addrErr && !st_r.addrSeen && !regRd |=> st_r.addrErr;
  endproperty
  a_addrNoClearUnread: assert property (p_addrNoClearUnread) else $error("Error cleared unread"); // [RULE_09]

  // Master enable low removes permission from every channel.
  property p_permitMaster;
    !st_r.masterEn |-> chanPermit == 6'h00;
  endproperty
  a_permitMaster: assert property (p_permitMaster) else $error("Permit without master enable"); // [RULE_13]

  // No grant starts while master enable is low.
  property p_masterOffIdle;
    !st_r.busy && !st_r.masterEn |=> !grantValid;
  endproperty
  a_masterOffIdle: assert property (p_masterOffIdle) else $error("Grant without master enable"); // [RULE_13]

  // A disabled or finished channel is never permitted.
  property p_permitEnd;
    (chanPermit & (~chanEnable | chanTransferEnd)) == 6'h00;
  endproperty
  a_permitEnd: assert property (p_permitEnd) else $error("Permit for a stopped channel"); // [RULE_14]

  // With no eligible requester the arbiter stays idle.
  property p_noPickNoGrant;
    !st_r.busy && !pick[3] |=> !grantValid;
  endproperty
  a_noPickNoGrant: assert property (p_noPickNoGrant) else $error("Grant without a requester"); // [RULE_14]

  // No new grant while the address-error flag is set.
  property p_addrNoGrant;
    !st_r.busy && st_r.addrErr |=> !grantValid;
  endproperty
  a_addrNoGrant: assert property (p_addrNoGrant) else $error("Grant during address error"); // [RULE_08]

  // A running unit is cut at once by an address error.
  property p_addrErrAbort;
    st_r.busy && st_r.addrErr |=> !grantValid;
  endproperty
  a_addrErrAbort: assert property (p_addrErrAbort) else $error("Unit kept after address error"); // [RULE_08]

  // No new grant while the NMI flag is set.
  property p_nmiNoGrant;
    !st_r.busy && st_r.nmiFlag |=> !grantValid;
  endproperty
  a_nmiNoGrant: assert property (p_nmiNoGrant) else $error("Grant while NMI flag set"); // [RULE_10]

  // The NMI flag sets from an idle arbiter as well.
  property p_nmiIdle;
    $rose(st_r.nmiS2) && !st_r.busy |=> st_r.nmiFlag;
  endproperty
  a_nmiIdle: assert property (p_nmiIdle) else $error("NMI flag not set while idle"); // [RULE_11]

  // A running unit keeps its grant and channel until it ends.
  property p_grantHold;
    s_unitHolds |=> grantValid && $stable(grantChannel);
  endproperty
  a_grantHold: assert property (p_grantHold) else $error("Grant dropped mid unit"); // [RULE_12]

  // Clearing the granted channel's own enable stops its unit.
  property p_chanOffAbort;
    st_r.busy && !chanEnable[st_r.chan] |=> !grantValid;
  endproperty
  a_chanOffAbort: assert property (p_chanOffAbort) else $error("Unit kept after channel off"); // [RULE_17]

  // The channel just served becomes the round-robin reference.
  property p_rrLastUpdate;
    s_unitEnds |=> st_r.rrLast == $past(st_r.chan);
  endproperty
  a_rrLastUpdate: assert property (p_rrLastUpdate) else $error("Round-robin pointer stale"); // [RULE_18]

  // The end pulse lasts one cycle, since the grant drops with it.
  property p_endPulseOne;
    transferEndSet != 6'h00 |=> transferEndSet == 6'h00;
  endproperty
  a_endPulseOne: assert property (p_endPulseOne) else $error("End pulse longer than a cycle"); // [RULE_16]

  // Every end pulse also records the end event in the status.
  property p_endIrq;
    transferEndSet != 6'h00 |-> st_r.irqStat[IRQ_END];
  endproperty
  a_endIrq: assert property (p_endIrq) else $error("End pulse without status bit"); // [RULE_16]

endmodule // dgoc_top

`default_nettype wire

// *** verif/dgoc_top_bench.sv ***
// Self-checking bench for the global operation control block of the DMA.
// Assumes dgoc_top with the register indices of dgoc_pkg and one 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module dgoc_top_bench
  import dgoc_pkg::*;
;
  logic        clk_sys, nrst, regWr, regRd, unitDone, unitLast;
  logic        addrErrorEvent, nmiPin, grantValid, irq;
  logic [1:0]  regAddr;
  logic [15:0] regWrData, regRdData;
  logic [5:0]  chanEnable, chanTransferEnd, chanRequest, chanPermit, transferEndSet;
  logic [2:0]  grantChannel;
  int          miscompares, nTests, cycles;

  dgoc_top dut (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .chanEnable(chanEnable),
    .chanTransferEnd(chanTransferEnd), .chanRequest(chanRequest), .unitDone(unitDone),
    .unitLast(unitLast), .addrErrorEvent(addrErrorEvent), .nmiPin(nmiPin),
    .chanPermit(chanPermit), .grantValid(grantValid), .grantChannel(grantChannel),
    .transferEndSet(transferEndSet), .irq(irq));

  // Free-running system clock, 50 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Every comparison is counted; a mismatch is reported at once.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic testDone();
    $display("Checks %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hang would otherwise stall the run; the whole sequence needs well under 1000 cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      testDone();
    end
  end

  // One-cycle write strobe with address and data.
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk_sys);
    regWr     <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken at that edge.
  task automatic rd(input logic [1:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    @(posedge clk_sys);
    chk(what, exp, regRdData);
  endtask

  // Raise requests and wait, bounded, for the grant, then check the winner.
  task automatic start(input logic [5:0] req, input logic [2:0] ch);
    @(posedge clk_sys);
    chanRequest <= req;
    for (int i = 0; i < 8 && grantValid !== 1'b1; i++) @(posedge clk_sys);
    chanRequest <= 6'h00;
    chk("grant channel", {13'h0, ch}, {13'h0, grantChannel});
  endtask

  // Finish the granted unit and check the end pulse that follows it.
  task automatic finish(input logic last, input logic [5:0] endExp);
    unitDone <= 1'b1;
    unitLast <= last;
    @(posedge clk_sys);
    unitDone <= 1'b0;
    @(posedge clk_sys);
    chk("grant release", 16'h0, {15'h0, grantValid});
    chk("end pulse", {10'h0, endExp}, {10'h0, transferEndSet});
  endtask

  // Main sequence: inputs settle at time zero, reset is held for eight cycles.
  initial begin
    {regWr, regRd, unitDone, unitLast, addrErrorEvent, nmiPin, nrst} = '0;
    {regAddr, regWrData, chanTransferEnd, chanRequest} = '0;
    chanEnable = 6'h3F;
    miscompares = 0;
    nTests = 0;
    cycles = 0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(ADDR_GLOBAL, GLOBAL_RESET, "global after reset");
    chk("permit without master", 16'h0, {10'h0, chanPermit});
    rd(2'h3, 16'h0000, "unmapped");
    wr(ADDR_GLOBAL, 16'h0307);
    rd(ADDR_GLOBAL, 16'h0301, "global image");
    $display("Test register image done");
    // Round-robin starts at channel 0 and moves past the channel just served.
    for (int k = 0; k < 3; k++) begin
      start(6'h3F, 3'(k));
      finish(1'b0, 6'h00);
    end
    start(6'h05, 3'h0);
    finish(1'b1, 6'h01);
    $display("Test round robin done");
    wr(ADDR_GLOBAL, 16'h0001);
    start(6'h3A, 3'h1);
    finish(1'b0, 6'h00);
    wr(ADDR_GLOBAL, 16'h0101);
    start(6'h3A, 3'h3);
    finish(1'b0, 6'h00);
    start(6'h06, 3'h2);
    finish(1'b0, 6'h00);
    chanEnable      <= 6'h1F;
    chanTransferEnd <= 6'h04;
    @(posedge clk_sys);
    chk("permit per channel", 16'h001B, {10'h0, chanPermit});
    chanEnable      <= 6'h3F;
    chanTransferEnd <= 6'h00;
    $display("Test fixed order and permit done");
    // Dropping the master enable in mid-unit aborts without an end pulse.
    start(6'h10, 3'h4);
    wr(ADDR_GLOBAL, 16'h0100);
    repeat (2) @(posedge clk_sys);
    chk("abort", 16'h0, {9'h0, grantValid, transferEndSet});
    $display("Test master abort done");
    // Address error: a clear only works after the flag was read as one.
    wr(ADDR_GLOBAL, 16'h0001);
    wr(ADDR_IRQ_STAT, 16'h0007);
    wr(ADDR_IRQ_MASK, 16'h0002);
    @(posedge clk_sys);
    addrErrorEvent <= 1'b1;
    @(posedge clk_sys);
    addrErrorEvent <= 1'b0;
    wr(ADDR_GLOBAL, 16'h0001);
    rd(ADDR_GLOBAL, 16'h0005, "error flag kept");
    chk("permit blocked", 16'h0, {10'h0, chanPermit});
    chk("masked irq", 16'h0, {15'h0, irq});
    rd(ADDR_IRQ_STAT, 16'h0001, "irq status");
    wr(ADDR_GLOBAL, 16'h0005);
    rd(ADDR_GLOBAL, 16'h0005, "error after one");
    wr(ADDR_GLOBAL, 16'h0001);
    rd(ADDR_GLOBAL, 16'h0001, "error cleared");
    $display("Test address error done");
    // NMI in mid-unit: the unit completes, then no new grant is given.
    start(6'h01, 3'h0);
    nmiPin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("unit continues", 16'h1, {15'h0, grantValid});
    chk("nmi irq", 16'h1, {15'h0, irq});
    finish(1'b0, 6'h00);
    nmiPin      <= 1'b0;
    chanRequest <= 6'h01;
    repeat (4) @(posedge clk_sys);
    chk("nmi blocks", 16'h0, {9'h0, grantValid, chanPermit});
    chanRequest <= 6'h00;
    rd(ADDR_GLOBAL, 16'h0003, "nmi flag");
    wr(ADDR_GLOBAL, 16'h0001);
    rd(ADDR_GLOBAL, 16'h0001, "nmi cleared");
    nmiPin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(ADDR_GLOBAL, 16'h0003, "nmi while idle");
    wr(ADDR_IRQ_STAT, 16'h0007);
    @(posedge clk_sys);
    chk("irq cleared", 16'h0, {15'h0, irq});
    $display("Test nmi done");
    testDone();
  end

endmodule // dgoc_top_bench

`default_nettype wire
